// *** rtl/dsw_pkg.sv ***
// Shared constants for the deep sleep watchdog
package dsw_pkg;

  // ************************************************************
  // Configuration word layout
  // ************************************************************
  localparam int CFG_WIDTH = 5;          // Width of the deep sleep configuration word
  localparam int PERIOD_SEL_LSB = 0;     // Period select field, low bit
  localparam int PERIOD_SEL_WIDTH = 4;   // Period select field, four bits
  localparam int CLOCK_SEL_BIT = 4;      // Clock source select bit
  localparam logic CLOCK_SEL_XTAL = 1'h0; // Select the secondary crystal oscillator
  localparam logic CLOCK_SEL_RC = 1'h1; // Select the low-power RC oscillator

  // ************************************************************
  // Postscaler and counter
  // ************************************************************
  localparam int NOMINAL_OSC_HZ = 31000; // Nominal watchdog oscillator rate in Hz
  localparam int MIN_SHIFT = 6;          // Shortest period: 2**6 ticks, about 2.1 ms
  localparam int SHIFT_STEP = 2;         // Each code step multiplies the period by four
  localparam int COUNT_WIDTH = 36;       // Longest period: 2**36 ticks, about 25.7 days

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [COUNT_WIDTH-1:0] COUNT_RESET = 36'h0_0000_0000; // Counter reset value
  localparam logic [PERIOD_SEL_WIDTH-1:0] PERIOD_SEL_RESET = 4'hF;  // Longest period until strapped
  localparam logic [1:0] SYNC_RESET = 2'h0;                         // Synchroniser reset value

  // Counter states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_COUNT = 3'h2,
    ST_EXPIRED = 3'h4
  } wdog_state_t;

endpackage

// *** rtl/osc_tick_if.sv ***
// Tick carrier from an oscillator edge detector to the watchdog counter
`timescale 1ns/1ps
interface osc_tick_if;
  logic tick; // One core_clk pulse per rising oscillator edge
  modport src (output tick);
  modport dst (input tick);
endinterface

// *** rtl/osc_tick_sync.sv ***
// Oscillator pin synchroniser and rising edge detector
`timescale 1ns/1ps
module osc_tick_sync (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic osc_pin,
  osc_tick_if.src tick_out
);

  // ************************************************************
  // Two-stage synchroniser, then one history stage
  // ************************************************************
  logic meta_reg;   // First stage, read only by the second stage
  logic sync_reg;   // Second stage, safe to use
  logic hist_reg;   // Previous synchronised level
  logic tick_reg;   // Registered edge pulse

  // Sample the slow oscillator; it must run well below core_clk/2
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      meta_reg <= dsw_pkg::SYNC_RESET[0];
      sync_reg <= dsw_pkg::SYNC_RESET[0];
      hist_reg <= dsw_pkg::SYNC_RESET[0];
    end else begin
      meta_reg <= osc_pin;
      sync_reg <= meta_reg;
      hist_reg <= sync_reg;
    end
  end

  // Rising edge becomes a single-cycle tick
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= sync_reg & ~hist_reg;
    end
  end

  assign tick_out.tick = tick_reg;

endmodule

// *** rtl/deep_sleep_wdog.sv ***
// Deep sleep watchdog: clock selection, postscaled counter and wake event
`timescale 1ns/1ps
module deep_sleep_wdog #(
  parameter int MIN_SHIFT = dsw_pkg::MIN_SHIFT,
  parameter int SHIFT_STEP = dsw_pkg::SHIFT_STEP,
  parameter int COUNT_WIDTH = dsw_pkg::COUNT_WIDTH
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [dsw_pkg::CFG_WIDTH-1:0] deep_sleep_config_word,
  input wire logic deep_sleep_wdog_enable,
  input wire logic deep_sleep_active,
  input wire logic secondary_crystal_osc,
  input wire logic low_power_rc_osc,
  output logic secondary_crystal_osc_enable,
  output logic low_power_rc_osc_enable,
  output logic deep_sleep_wdog_wake,
  output logic deep_sleep_wdog_timeout,
  output logic [COUNT_WIDTH-1:0] deep_sleep_wdog_count
);

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  // The longest setting must still fit in the counter
  // The shift amount travels in six bits, so the longest setting must stay below 64
  if (MIN_SHIFT < 1 || SHIFT_STEP < 1 || COUNT_WIDTH < MIN_SHIFT + 15 * SHIFT_STEP ||
      MIN_SHIFT + 15 * SHIFT_STEP > 63) begin : g_bad_params
    $error("deep_sleep_wdog: counter too narrow for the period range");
  end

  // ************************************************************
  // Oscillator edge detectors
  // ************************************************************
  osc_tick_if xtal_if ();  // Crystal oscillator ticks
  osc_tick_if rc_if ();  // RC oscillator ticks

  osc_tick_sync u_xtal_tick (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .osc_pin(secondary_crystal_osc),
    .tick_out(xtal_if.src)
  );

  osc_tick_sync u_rc_tick (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .osc_pin(low_power_rc_osc),
    .tick_out(rc_if.src)
  );

  // ************************************************************
  // Configuration capture
  // ************************************************************
  logic cfg_loaded_reg;                                  // Straps captured once after reset
  logic clock_sel_reg;                                   // Chosen oscillator
  logic [dsw_pkg::PERIOD_SEL_WIDTH-1:0] period_sel_reg;  // Chosen postscaler code
  logic enable_reg;                                      // Watchdog enabled by configuration

  // Straps are taken on the first clock after reset release, never inside reset,
  // so the configuration stays fixed for the whole run
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cfg_loaded_reg <= 1'b0;
      clock_sel_reg <= dsw_pkg::CLOCK_SEL_XTAL;
      period_sel_reg <= dsw_pkg::PERIOD_SEL_RESET;
      enable_reg <= 1'b0;
    end else if (!cfg_loaded_reg) begin
      cfg_loaded_reg <= 1'b1;
      clock_sel_reg <= deep_sleep_config_word[dsw_pkg::CLOCK_SEL_BIT];
      period_sel_reg <= deep_sleep_config_word[dsw_pkg::PERIOD_SEL_LSB +: dsw_pkg::PERIOD_SEL_WIDTH];
      enable_reg <= deep_sleep_wdog_enable;
    end
  end

  // ************************************************************
  // Decode
  // ************************************************************
  wire sel_tick;                          // Tick of the chosen oscillator
  wire running;                           // Counter allowed to advance
  wire [5:0] period_shift;                // log2 of the period in ticks
  wire [COUNT_WIDTH-1:0] terminal;        // Last count before expiry
  wire at_terminal;                       // Next tick expires
  wire xtal_en_next; // Crystal enable request
  wire rc_en_next; // RC enable request
  // Counter reset value at this instance's width; the package holds it at the default 36-bit width
  localparam logic [COUNT_WIDTH-1:0] COUNT_INIT = COUNT_WIDTH'(dsw_pkg::COUNT_RESET);

  assign sel_tick = (clock_sel_reg == dsw_pkg::CLOCK_SEL_RC) ? rc_if.tick : xtal_if.tick;
  assign running = cfg_loaded_reg & enable_reg & deep_sleep_active;
  // Each code multiplies the period by 2**SHIFT_STEP; code 0 is the shortest
  assign period_shift = 6'(MIN_SHIFT + SHIFT_STEP * int'(period_sel_reg));
  assign terminal = (COUNT_WIDTH'(1) << period_shift) - COUNT_WIDTH'(1);
  // The oscillator is kept alive as long as the watchdog is enabled, asleep or not
  assign xtal_en_next = cfg_loaded_reg & enable_reg & (clock_sel_reg == dsw_pkg::CLOCK_SEL_XTAL);
  assign rc_en_next = cfg_loaded_reg & enable_reg & (clock_sel_reg == dsw_pkg::CLOCK_SEL_RC);

  // ************************************************************
  // Counter state machine
  // ************************************************************
  dsw_pkg::wdog_state_t state_reg;     // Current state
  dsw_pkg::wdog_state_t state_next;    // Next state
  logic [COUNT_WIDTH-1:0] count_reg;   // Postscaled tick count
  logic [COUNT_WIDTH-1:0] count_next;  // Next count
  logic wake_next;                     // Expiry in this cycle

  // Terminal compare needs the count, so it follows the count's declaration
  assign at_terminal = (count_reg == terminal);

  // Leaving deep sleep always restarts the count from zero
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    wake_next = 1'b0;
    case (state_reg)
      dsw_pkg::ST_IDLE: begin
        count_next = COUNT_INIT;
        if (running) begin
          state_next = dsw_pkg::ST_COUNT;
        end
      end
      dsw_pkg::ST_COUNT: begin
        if (!running) begin
          // Woken by something else, or disabled
          state_next = dsw_pkg::ST_IDLE;
          count_next = COUNT_INIT;
        end else if (sel_tick && at_terminal) begin
          state_next = dsw_pkg::ST_EXPIRED;
          wake_next = 1'b1;
        end else if (sel_tick) begin
          count_next = count_reg + COUNT_WIDTH'(1);
        end
      end
      dsw_pkg::ST_EXPIRED: begin
        // Hold until the power controller leaves deep sleep
        if (!deep_sleep_active) begin
          state_next = dsw_pkg::ST_IDLE;
          count_next = COUNT_INIT;
        end
      end
      default: begin
        state_next = dsw_pkg::ST_IDLE;
        count_next = COUNT_INIT;
      end
    endcase
  end

  // State and count registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg <= dsw_pkg::ST_IDLE;
      count_reg <= COUNT_INIT;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  logic wake_reg;      // One-cycle wake request
  logic timeout_reg;   // Sticky time-out flag
  logic xtal_en_reg; // Crystal enable
  logic rc_en_reg; // RC enable

  // Timeout is set only while asleep and cleared only when awake, so they never collide
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wake_reg <= 1'b0;
      timeout_reg <= 1'b0;
      xtal_en_reg <= 1'b0;
      rc_en_reg <= 1'b0;
    end else begin
      wake_reg <= wake_next;
      timeout_reg <= wake_next | (timeout_reg & deep_sleep_active);
      xtal_en_reg <= xtal_en_next;
      rc_en_reg <= rc_en_next;
    end
  end

  assign deep_sleep_wdog_wake = wake_reg;
  assign deep_sleep_wdog_timeout = timeout_reg;
  assign deep_sleep_wdog_count = count_reg;
  assign secondary_crystal_osc_enable = xtal_en_reg;
  assign low_power_rc_osc_enable = rc_en_reg;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_count_clears_awake;
    !deep_sleep_active |=> count_reg == COUNT_INIT;
  endproperty
  a_count_clears_awake: assert property (p_count_clears_awake) else $error("count not cleared when awake");

  property p_count_steps;
    state_reg == dsw_pkg::ST_COUNT && running && sel_tick && !at_terminal |=> count_reg == $past(count_reg) + 1'b1;
  endproperty
  a_count_steps: assert property (p_count_steps) else $error("count did not step on a tick");

  property p_no_tick_hold;
    state_reg == dsw_pkg::ST_COUNT && running && !sel_tick |=> count_reg == $past(count_reg);
  endproperty
  a_no_tick_hold: assert property (p_no_tick_hold) else $error("count moved without a selected tick");

  property p_wake_at_terminal;
    wake_reg |-> $past(count_reg) == $past(terminal) && $past(sel_tick);
  endproperty
  a_wake_at_terminal: assert property (p_wake_at_terminal) else $error("wake not at the period end");

  property p_period_strap;
    $rose(cfg_loaded_reg) |->
      period_sel_reg == $past(deep_sleep_config_word[dsw_pkg::PERIOD_SEL_LSB +: dsw_pkg::PERIOD_SEL_WIDTH]);
  endproperty
  a_period_strap: assert property (p_period_strap) else $error("period code not taken from bits 3:0");

  property p_osc_enabled;
    running ##1 running |-> (clock_sel_reg ? low_power_rc_osc_enable : secondary_crystal_osc_enable);
  endproperty
  a_osc_enabled: assert property (p_osc_enabled) else $error("selected oscillator not enabled");

  property p_wake_pulse;
    wake_reg && deep_sleep_active |=> !wake_reg && timeout_reg;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake not a single pulse with flag");

  property p_binary_ratio;
    wake_reg |-> $past(count_reg) + 1'b1 == (COUNT_WIDTH'(1) << $past(period_shift));
  endproperty
  a_binary_ratio: assert property (p_binary_ratio) else $error("period not a power of two");

  c_wake: cover property (running ##[1:1000] wake_reg);
  c_rc_run: cover property (running && clock_sel_reg && sel_tick);
  c_early_exit: cover property (state_reg == dsw_pkg::ST_COUNT ##1 !deep_sleep_active);

endmodule

// *** test/deep_sleep_wdog_test.sv ***
// Self-checking testbench for the deep sleep watchdog
`timescale 1ns/1ps
module deep_sleep_wdog_test;
  // ************************************************************
  // Stimulus, observation and bookkeeping
  // ************************************************************
  localparam int MIN_SHIFT = 2; // Short periods keep the run brief
  localparam int SHIFT_STEP = 1; // One doubling per code step
  localparam int COUNT_WIDTH = 17; // Wide enough for every code
  logic core_clk = 1'h0;
  logic rst_n = 1'h0;
  logic [dsw_pkg::CFG_WIDTH-1:0] cfg = 5'h00; // Configuration word
  logic wd_en = 1'h0;
  logic asleep = 1'h0;
  logic xtal_pin = 1'h0;
  logic rc_pin = 1'h0;
  logic xtal_en, rc_en, wake, timeout;
  logic [COUNT_WIDTH-1:0] count;
  int num_errors = 0;
  int n_checks = 0;
  int wake_cnt = 0; // Wake pulses seen since the last reset
  always #5 core_clk = ~core_clk;
  deep_sleep_wdog #(.MIN_SHIFT(MIN_SHIFT), .SHIFT_STEP(SHIFT_STEP), .COUNT_WIDTH(COUNT_WIDTH)) dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .deep_sleep_config_word(cfg), .deep_sleep_wdog_enable(wd_en),
    .deep_sleep_active(asleep), .secondary_crystal_osc(xtal_pin), .low_power_rc_osc(rc_pin),
    .secondary_crystal_osc_enable(xtal_en), .low_power_rc_osc_enable(rc_en),
    .deep_sleep_wdog_wake(wake), .deep_sleep_wdog_timeout(timeout), .deep_sleep_wdog_count(count));
  // Wake is a one-cycle pulse, so it is counted every cycle rather than polled
  always @(posedge core_clk) begin
    if (!rst_n) begin
      wake_cnt <= 0;
    end else if (wake === 1'h1) begin
      wake_cnt <= wake_cnt + 1;
    end
  end
  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // Reset with the strap values set up front; they are captured once on release
  task automatic restart(input logic [4:0] word, input logic en);
    @(posedge core_clk);
    rst_n <= 1'h0;
    asleep <= 1'h0;
    cfg <= word;
    wd_en <= en;
    repeat (3) @(posedge core_clk);
    check("outputs in reset", {11'h0, xtal_en, rc_en, wake, timeout, count}, 32'h0);
    rst_n <= 1'h1;
    repeat (3) @(posedge core_clk);
  endtask
  // Full oscillator cycles, high and low two core cycles each, then let sync settle
  task automatic pulses(input logic rc, input int n);
    repeat (n) begin
      @(posedge core_clk);
      if (rc) rc_pin <= 1'h1;
      else xtal_pin <= 1'h1;
      repeat (2) @(posedge core_clk);
      rc_pin <= 1'h0;
      xtal_pin <= 1'h0;
      @(posedge core_clk);
    end
    repeat (6) @(posedge core_clk);
  endtask
  task automatic end_sim();
    $display("Checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  // Each select value enables only its own oscillator, and disable enables neither
  task automatic test_osc_enable();
    restart({dsw_pkg::CLOCK_SEL_XTAL, 4'h0}, 1'h1);
    check("crystal enables", {30'h0, xtal_en, rc_en}, 32'h2);
    restart({dsw_pkg::CLOCK_SEL_RC, 4'h0}, 1'h1);
    check("rc enables", {30'h0, xtal_en, rc_en}, 32'h1);
    cfg <= {dsw_pkg::CLOCK_SEL_XTAL, 4'h0};
    repeat (3) @(posedge core_clk);
    check("late change ignored", {30'h0, xtal_en, rc_en}, 32'h1);
    restart({dsw_pkg::CLOCK_SEL_RC, 4'h0}, 1'h0);
    asleep <= 1'h1;
    pulses(1'h1, 3);
    check("disabled enables and count", {30'h0, xtal_en, rc_en} | count, 32'h0);
    $display("test_osc_enable done");
  endtask
  // Only the selected oscillator advances the count, and only in deep sleep
  task automatic test_source_and_sleep();
    restart({dsw_pkg::CLOCK_SEL_XTAL, 4'h3}, 1'h1);
    pulses(1'h0, 3);
    check("awake count", count, 32'h0);
    asleep <= 1'h1;
    pulses(1'h1, 3);
    check("unselected osc count", count, 32'h0);
    pulses(1'h0, 3);
    check("selected osc count", count, 32'h3);
    restart({dsw_pkg::CLOCK_SEL_RC, 4'h3}, 1'h1);
    asleep <= 1'h1;
    pulses(1'h0, 2);
    pulses(1'h1, 5);
    check("rc osc count", count, 32'h5);
    $display("test_source_and_sleep done");
  endtask
  // Expiry lands exactly on the period of the code under test, wakes once and clears on exit
  task automatic test_period(input logic [3:0] code, input logic rc);
    int ticks;
    ticks = 1 << (MIN_SHIFT + SHIFT_STEP * code);
    restart({rc, code}, 1'h1);
    asleep <= 1'h1;
    pulses(rc, ticks - 1);
    check("count before expiry", count, ticks - 1);
    check("no early wake", {wake_cnt[30:0], timeout}, 32'h0);
    pulses(rc, 1);
    check("wake at expiry", wake_cnt, 32'h1);
    check("timeout flag", {31'h0, timeout}, 32'h1);
    pulses(rc, 4);
    check("single wake", wake_cnt, 32'h1);
    asleep <= 1'h0;
    repeat (3) @(posedge core_clk);
    check("flag cleared", {31'h0, timeout}, 32'h0);
    check("count cleared", count, 32'h0);
    asleep <= 1'h1;
    pulses(rc, 2);
    check("restart from zero", count, 32'h2);
    $display("test_period code %0d done", code);
  endtask
  // ************************************************************
  // Main sequence and watchdog
  // ************************************************************
  initial begin
    repeat (2) @(posedge core_clk);
    test_osc_enable();
    test_source_and_sleep();
    test_period(4'h0, dsw_pkg::CLOCK_SEL_XTAL);
    test_period(4'h1, dsw_pkg::CLOCK_SEL_RC);
    test_period(4'h2, dsw_pkg::CLOCK_SEL_XTAL);
    test_period(4'h4, dsw_pkg::CLOCK_SEL_RC);
    end_sim();
  end
  // Whole run is about 750 cycles; this limit is far beyond it
  initial begin
    #500000;
    num_errors++;
    $display("Error watchdog expired before tests finished");
    end_sim();
  end
endmodule
